// ===== design/lrd_pkg.sv
// Purpose: shared constants and types for the redriver lane control
// Assumes: 50 ns control clock
// Notes: timing counts derive from printed times, except DETECT_WAIT_CYC
package lrd_pkg;
  localparam int NCH = 4;
  localparam int CLK_NS = 50;
  // least times round up, longest times round down, never below one cycle
  localparam int IDLE_ENTRY_NS = 20;
  localparam int IDLE_ENTRY_CYC = (IDLE_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_NS = 1000;
  localparam int SLEEP_CYC = SLEEP_NS / CLK_NS + 1;
  localparam int SAMPLE_NS = 50000;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int ACTIVE_MS = 250;
  localparam int ACTIVE_CYC = ACTIVE_MS * 1000000 / CLK_NS;
  localparam int RETRY_NS = 10000;
  localparam int RETRY_CYC = RETRY_NS / CLK_NS;
  localparam int DETECT_WAIT_CYC = 4;
  localparam int LIMIT_TRIES = 5;
  localparam int SYNC_W = 18;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CHAN = 12'h008;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int CTRL_NOSLEEP_BIT = 1;
  localparam logic [1:0] PAD_LOW = 2'h1;
  localparam logic [1:0] PAD_HIGH = 2'h2;
  localparam logic [1:0] THR_LOW = 2'h0;
  localparam logic [1:0] THR_MID = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_DETECT = 3'b010,
    ST_LIMITED = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_FORCED = 3'b101
  } lrd_state_t;
  typedef struct packed {
    logic [NCH-1:0] term_high_z;
    logic [NCH-1:0] power_on;
    logic [NCH-1:0] tx_idle;
    logic [NCH-1:0] sleep;
    logic [NCH-1:0] squelch_en;
  } lrd_chan_t;
endpackage

// ===== design/lrd_lane_ctrl.sv
// Purpose: lane control of a four channel PCIe redriver
// Assumes: analog comparators and detect circuits outside, asynchronous
// Notes: APB slave for software control and status
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module lrd_lane_ctrl
  import lrd_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic rx_detect_enable,
  input wire logic auto_low_power_select,
  input wire logic squelch_slave_select,
  input wire logic [1:0] idle_threshold_select,
  input wire logic [NCH-1:0] rx_below_min,
  input wire logic [NCH-1:0] rx_above_max,
  input wire logic [NCH-1:0] term_found,
  output lrd_chan_t chan,
  output logic [NCH-1:0] detect_strobe,
  output logic [1:0] idle_threshold_voltage,
  output logic tx_high_z
);
  if (ACTIVE_CYCLES < 1 || ACTIVE_CYCLES > 32'h00FFFFFF) begin : g_chk
    $error("ACTIVE_CYCLES out of range");
  end
  if (SAMPLE_CYC < 4 || RETRY_CYC <= DETECT_WAIT_CYC) begin : g_chk2
    $error("timing constants too small");
  end

  function automatic logic [2:0] ones(input logic [NCH-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < NCH; k++) begin
      n = n + {2'h0, v[k]};
    end
    return n;
  endfunction

  // two-flop synchroniser; stage one feeds stage two only
  logic [SYNC_W-1:0] sync1, sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= {reset_pin_n, rx_detect_enable, auto_low_power_select,
                squelch_slave_select, idle_threshold_select, rx_below_min,
                rx_above_max, term_found};
      sync2 <= sync1;
    end
  end
  logic rst_pin_s, rxd_en_s, alp_sel_s, slave_s;
  logic [1:0] thr_pad_s;
  logic [NCH-1:0] below_s, above_s, found_s;
  assign {rst_pin_s, rxd_en_s, alp_sel_s, slave_s, thr_pad_s, below_s,
          above_s, found_s} = sync2;

  // register file
  logic [1:0] ctrl, next_ctrl;
  logic [31:0] next_prdata;
  logic next_pslverr;
  lrd_state_t state, next_state;
  logic [NCH-1:0] found, next_found, power, next_power;
  logic [NCH-1:0] idle, next_idle, sleep, next_sleep;
  logic alp_ok;
  logic setup, wr;
  assign pready = ce;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && ce;

  always_comb begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (wr && paddr == REG_CTRL) begin
      next_ctrl = pwdata[1:0];
    end
    if (setup) begin
      next_pslverr = 1'b0;
      case (paddr)
        REG_CTRL: next_prdata = {30'h0, ctrl};
        REG_STATUS: next_prdata = {20'h0, alp_ok, state, found, power};
        REG_CHAN: next_prdata = {16'h0, thr_pad_s, 2'h0, slave_s,
                                 alp_sel_s, rxd_en_s, rst_pin_s, idle, sleep};
        default: begin
          next_prdata = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // detection sequencer
  logic [7:0] retry, next_retry;
  logic [2:0] tries, next_tries;
  logic [23:0] act_cnt, next_act_cnt;
  logic [NCH-1:0] next_strobe;
  logic hold_standby, detecting, sample_now;
  // presetn is the power-on reset; the pin reset acts through sync
  assign hold_standby = !rst_pin_s || ctrl[CTRL_STANDBY_BIT];
  assign detecting = state == ST_DETECT || state == ST_LIMITED;
  assign sample_now = detecting && retry == 8'(DETECT_WAIT_CYC);

  always_comb begin
    next_state = state;
    next_found = found;
    next_power = power;
    next_tries = tries;
    next_retry = retry;
    next_strobe = '0;
    next_act_cnt = act_cnt;
    if (detecting) begin
      next_retry = (retry == 8'(RETRY_CYC - 1)) ? 8'h0 : retry + 8'h1;
      if (retry == 8'h0) begin
        next_strobe = ~found;
      end
    end
    case (state)
      ST_STANDBY: begin
        next_power = '0;
        next_found = '0;
        next_act_cnt = '0;
        if (!hold_standby) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // a few cycles after release, well inside the bound
        next_retry = 8'h0;
        next_state = rxd_en_s ? ST_DETECT : ST_FORCED;
      end
      ST_DETECT: begin
        if (sample_now) begin
          next_found = found_s;
          if (found_s != '0) begin
            next_tries = 3'h0;
            next_state = ST_LIMITED;
          end
        end
      end
      ST_LIMITED: begin
        if (sample_now) begin
          next_found = found | found_s;
          next_tries = tries + 3'h1;
          if (tries == 3'(LIMIT_TRIES - 1)) begin
            next_state = ST_ACTIVE;
            if (ones(found | found_s) == 3'h3) begin
              next_power = '1;
            end else begin
              next_power = found | found_s;
            end
          end
        end
      end
      ST_ACTIVE, ST_FORCED: begin
        if (state == ST_FORCED) begin
          next_power = '1;
        end
        if (act_cnt != 24'(ACTIVE_CYCLES)) begin
          next_act_cnt = act_cnt + 24'h1;
        end
      end
      default: next_state = ST_STANDBY;
    endcase
    if (hold_standby) begin
      next_state = ST_STANDBY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_STANDBY;
      found <= '0;
      power <= '0;
      tries <= 3'h0;
      retry <= 8'h0;
      detect_strobe <= '0;
      act_cnt <= 24'h0;
    end else if (ce) begin
      state <= next_state;
      found <= next_found;
      power <= next_power;
      tries <= next_tries;
      retry <= next_retry;
      detect_strobe <= next_strobe;
      act_cnt <= next_act_cnt;
    end
  end

  // sleep needs the long active period, unbounded once reached
  assign alp_ok = alp_sel_s && !ctrl[CTRL_NOSLEEP_BIT] &&
                  act_cnt == 24'(ACTIVE_CYCLES);
  logic running;
  assign running = state == ST_ACTIVE || state == ST_FORCED;

  // per channel idle and sleep
  logic [NCH-1:0][4:0] cnt, next_cnt;
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic src_below, src_above;
    // slave mode: lane 1 decides for all lanes
    assign src_below = slave_s ? below_s[0] : below_s[i];
    assign src_above = slave_s ? above_s[0] : above_s[i];
    always_comb begin
      next_cnt[i] = cnt[i];
      next_idle[i] = idle[i];
      next_sleep[i] = sleep[i];
      if (!running || src_above) begin
        next_cnt[i] = 5'h0;
        next_idle[i] = 1'b0;
        next_sleep[i] = 1'b0;
      end else if (src_below) begin
        if (cnt[i] != 5'(SLEEP_CYC)) begin
          next_cnt[i] = cnt[i] + 5'h1;
        end
        if (cnt[i] >= 5'(IDLE_ENTRY_CYC - 1)) begin
          next_idle[i] = 1'b1;
        end
        if (alp_ok && cnt[i] >= 5'(SLEEP_CYC - 1)) begin
          next_sleep[i] = 1'b1;
        end
      end else begin
        next_cnt[i] = 5'h0;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[i] <= 5'h0;
        idle[i] <= 1'b0;
        sleep[i] <= 1'b0;
      end else if (ce) begin
        cnt[i] <= next_cnt[i];
        idle[i] <= next_idle[i];
        sleep[i] <= next_sleep[i];
      end
    end
  end

  // threshold pad: low, open (mid), high
  logic [1:0] next_thr;
  always_comb begin
    case (thr_pad_s)
      PAD_LOW: next_thr = THR_LOW;
      PAD_HIGH: next_thr = THR_HIGH;
      default: next_thr = THR_MID;
    endcase
  end

  logic stby;
  logic [NCH-1:0] sq_en;
  assign stby = state == ST_STANDBY;
  for (genvar j = 0; j < NCH; j++) begin : g_sq
    assign sq_en[j] = (j == 0) || !slave_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_threshold_voltage <= THR_MID;
      tx_high_z <= 1'b1;
      chan <= '{term_high_z: '1, power_on: '0, tx_idle: '0, sleep: '0,
                squelch_en: '1};
    end else if (ce) begin
      idle_threshold_voltage <= next_thr;
      tx_high_z <= stby;
      // forced mode keeps normal termination from its first cycle
      chan.term_high_z <= stby ? '1 : (state == ST_ACTIVE ? ~power : '0);
      // lanes report off together with the high-z termination, except between release and power-up
      chan.power_on <= stby ? '0 : power;
      chan.tx_idle <= idle;
      chan.sleep <= sleep;
      chan.squelch_en <= sq_en;
    end
  end
endmodule
`default_nettype wire

// ===== bench/lrd_lane_ctrl_assertions.sv
// Purpose: port checker for lrd_lane_ctrl
// Assumes: ce held high
// Notes: delays cover two sync flops and output registers
`timescale 1ns/1ns
`default_nettype none
module lrd_lane_ctrl_assertions
  import lrd_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic squelch_slave_select,
  input wire logic [NCH-1:0] rx_below_min,
  input wire logic [NCH-1:0] rx_above_max,
  input wire lrd_chan_t chan,
  input wire logic [NCH-1:0] detect_strobe,
  input wire logic tx_high_z
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    rx_below_min[0] && !rx_above_max[0] && chan.power_on[0];
  endsequence
  sequence s_loud;
    rx_above_max[0] && !rx_below_min[0];
  endsequence
  property p_standby;
    !reset_pin_n [*5] |=> tx_high_z && chan.power_on == 4'h0;
  endproperty
  a_standby: assert property (p_standby) else $error("standby missed");
  property p_term;
    chan.power_on != 4'h0 |-> chan.term_high_z == ~chan.power_on && detect_strobe == 4'h0;
  endproperty
  a_term: assert property (p_term) else $error("lane setup wrong");
  property p_three;
    $countones(chan.power_on) != 3;
  endproperty
  a_three: assert property (p_three) else $error("three lanes on");
  property p_idle;
    s_quiet [*6] |=> chan.tx_idle[0];
  endproperty
  a_idle: assert property (p_idle) else $error("idle missed");
  property p_exit;
    s_loud [*6] |=> !chan.tx_idle[0] && !chan.sleep[0];
  endproperty
  a_exit: assert property (p_exit) else $error("idle exit missed");
  property p_sleep;
    $rose(chan.sleep[0]) |-> $past(rx_below_min[0], 20) && chan.tx_idle[0];
  endproperty
  a_sleep: assert property (p_sleep) else $error("early sleep");
  property p_slave;
    $stable(squelch_slave_select) [*7] ##0 chan.power_on != 4'h0
      |-> chan.squelch_en == (squelch_slave_select ? 4'h1 : 4'hF);
  endproperty
  a_slave: assert property (p_slave) else $error("squelch mode wrong");
  property p_strobe;
    detect_strobe[1] |=> !detect_strobe[1] [*8];
  endproperty
  a_strobe: assert property (p_strobe) else $error("retry too soon");
endmodule
`default_nettype wire

// ===== bench/lrd_far_end.sv
// Purpose: far end of the four lanes, answers receiver detection
// Assumes: present marks lanes with a far-end termination
// Notes: sense line carries no meaning outside the answer window
`timescale 1ns/1ns
`default_nettype none
module lrd_far_end
  import lrd_pkg::*;
(
  input wire logic pclk,
  input wire logic [NCH-1:0] present,
  input wire logic [NCH-1:0] detect_strobe,
  output logic [NCH-1:0] term_found
);
  logic [3:0] age [NCH] = '{default: 4'h0};
  logic [NCH-1:0] answer = '0;
  assign term_found = answer;
  always @(posedge pclk) begin
    for (int i = 0; i < NCH; i++) begin
      age[i] <= detect_strobe[i] ? 4'hC : age[i] - {3'h0, age[i] != 4'h0};
      // toggles outside the window so a mistimed sample cannot pass by luck
      answer[i] <= (detect_strobe[i] || age[i] != 4'h0) ? present[i] : ~answer[i];
    end
  end
endmodule
`default_nettype wire

// ===== bench/lrd_lane_ctrl_bench.sv
// Purpose: self-checking bench for lrd_lane_ctrl
// Assumes: ce held high; active period before sleep cut to 50 cycles
// Notes: outputs are read at edges, before that edge's updates land
`timescale 1ns/1ns
`default_nettype none
module lrd_lane_ctrl_bench;
  import lrd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_high_z, reset_pin_n;
  logic rx_detect_enable, auto_low_power_select, squelch_slave_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] idle_threshold_select, idle_threshold_voltage;
  logic [NCH-1:0] rx_below_min, rx_above_max, term_found, detect_strobe, present;
  lrd_chan_t chan;
  int mismatches, checked, s0, s1;
  lrd_lane_ctrl #(.ACTIVE_CYCLES(50)) lrd_lane_ctrl_inst (.pclk, .presetn, .ce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n,
    .rx_detect_enable, .auto_low_power_select, .squelch_slave_select, .idle_threshold_select,
    .rx_below_min, .rx_above_max, .term_found, .chan, .detect_strobe,
    .idle_threshold_voltage, .tx_high_z);
  lrd_far_end lrd_far_end_inst (.pclk, .present, .detect_strobe, .term_found);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      stop_test();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for lanes to power up, counting detect attempts meanwhile
  task automatic await(input int lim, input bit need);
    int i;
    for (i = 0; i < lim && chan.power_on === 4'h0; i++) begin
      @(posedge pclk);
      s0 += detect_strobe[0];
      s1 += detect_strobe[1];
    end
    if (need && i == lim) begin
      chk("power up", 1, 0);
      stop_test();
    end
  endtask
  task automatic boot(input logic en, input logic [3:0] pres, input int lim);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    rx_detect_enable <= en;
    present <= pres;
    cyc(8);
    reset_pin_n <= 1'b1;
    s0 = 0;
    s1 = 0;
    await(lim, lim > 1000);
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_pin_n, rx_detect_enable, squelch_slave_select, present} = '0;
    {rx_below_min, rx_above_max, idle_threshold_select} = '0;
    auto_low_power_select = 1'b1;
    mismatches = 0;
    checked = 0;
    cyc(16);
    presetn <= 1'b1;
    boot(1'b1, 4'h1, 3000);
    chk("lane1 tries", 1, s0);
    chk("lane2 tries", 6, s1);
    chk("hi-z", 4'hE, chan.term_high_z);
    apb(1'b0, REG_STATUS, 0);
    chk("state", 4, q[10:8]);
    boot(1'b1, 4'h7, 3000);
    chk("power", 4'hF, chan.power_on);
    boot(1'b1, 4'h0, 700);
    chk("power", 0, chan.power_on);
    chk("retries", 1, s1 > 2);
    present <= 4'h4;
    await(3000, 1'b1);
    chk("hi-z", 4'hB, chan.term_high_z);
    boot(1'b0, 4'h0, 3000);
    chk("hi-z", 0, chan.term_high_z);
    chk("power", 4'hF, chan.power_on);
    rx_below_min <= 4'hF;
    cyc(30);
    chk("idle", 4'hF, chan.tx_idle);
    chk("sleep", 0, chan.sleep);
    cyc(40);
    chk("sleep", 4'hF, chan.sleep);
    rx_below_min <= 4'h0;
    rx_above_max <= 4'hF;
    cyc(6);
    chk("idle", 0, chan.tx_idle | chan.sleep);
    rx_above_max <= 4'h0;
    rx_below_min <= 4'h3;
    // just past 20 cycles of idle input: still awake
    cyc(21);
    chk("sleep", 0, chan.sleep);
    cyc(11);
    chk("sleep", 4'h3, chan.sleep);
    squelch_slave_select <= 1'b1;
    rx_below_min <= 4'h1;
    cyc(40);
    chk("sleep", 4'hF, chan.sleep);
    chk("squelch", 4'h1, chan.squelch_en);
    squelch_slave_select <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      idle_threshold_select <= k[1:0];
      cyc(6);
      chk("thr", k == 1 ? THR_LOW : k == 2 ? THR_HIGH : THR_MID, idle_threshold_voltage);
    end
    apb(1'b0, REG_CHAN, 0);
    chk("chan reg", 32'h0000C5FF, q);
    apb(1'b0, REG_STATUS, 0);
    chk("sleep allowed", 1, q[11]);
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b0, REG_STATUS, 0);
    chk("sleep barred", 0, q[11]);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 1, q);
    cyc(8);
    chk("tx hi-z", 1, tx_high_z);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], pslverr});
    apb(1'b1, REG_CTRL, 32'h0);
    reset_pin_n <= 1'b0;
    cyc(8);
    chk("hi-z", 4'hF, chan.term_high_z);
    reset_pin_n <= 1'b1;
    await(3000, 1'b1);
    presetn <= 1'b0;
    cyc(2);
    chk("reset", 4'h0, chan.power_on);
    stop_test();
  end
endmodule
bind lrd_lane_ctrl lrd_lane_ctrl_assertions #(.ACTIVE_CYCLES(ACTIVE_CYCLES))
  lrd_lane_ctrl_assertions_inst (.pclk, .presetn, .reset_pin_n, .squelch_slave_select,
  .rx_below_min, .rx_above_max, .chan, .detect_strobe, .tx_high_z);
`default_nettype wire
